// ### pkg/hwm_regs.svh
// Command codes, field positions, reset values and timing of the hardware monitor
`ifndef HWM_REGS_SVH
`define HWM_REGS_SVH

`define HWM_CMD_ID_MAKER      8'h3E
`define HWM_CMD_ID_STEP       8'h3F
`define HWM_CMD_READING_BASE  8'h20
`define HWM_CMD_READING_LAST  8'h27
`define HWM_CMD_LIMIT_BASE    8'h2B
`define HWM_CMD_LIMIT_LAST    8'h3A
`define HWM_CMD_CONFIG        8'h40
`define HWM_CMD_STATUS1       8'h41
`define HWM_CMD_STATUS2       8'h42
`define HWM_CMD_VCODE_LOW     8'h47
`define HWM_CMD_VCODE_HIGH    8'h49

`define HWM_CFG_START         0
`define HWM_CFG_RST_PULSE     4
`define HWM_CFG_SHARED_SEL    5
`define HWM_CFG_INIT          7
`define HWM_CFG_RESET         8'h08
`define HWM_CFG_WRITE_MASK    8'h31

`define HWM_ST2_12V           0
`define HWM_ST2_VDD           1
`define HWM_ST2_DIODE         6
`define HWM_ST2_DEFINED       8'h43
`define HWM_VCL_RST_EN        7
`define HWM_VCH_FIXED         8'h80

`define HWM_SLAVE_ADDR_HI     6'h16
`define HWM_ADDR_LATCH_DLY    2'h3

`define HWM_CLK_KHZ           250000
`define HWM_LOOP_MS           1000
`define HWM_RST_PULSE_MS      20

`endif

// ### pkg/hwm_pkg.sv
// Types shared by the hardware monitor design files
package hwm_pkg;
   typedef logic [7:0] hwm_byte_t;
   typedef enum logic [2:0] {SMB_IDLE, SMB_RX, SMB_ACK, SMB_TX, SMB_TXACK} hwm_smb_st_t;
   typedef enum logic [1:0] {MON_STANDBY, MON_CONV, MON_WAIT} hwm_mon_st_t;
endpackage

// ### hdl/hwm_sync.sv
// Two-flop synchroniser for pin levels entering the ref_clk domain
`timescale 1ns/1ps
module hwm_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } hwm_sync_state_t;

   hwm_sync_state_t s;
   hwm_sync_state_t next_s;

   always_comb begin
      next_s.first  = async_in;
      next_s.second = s.first;
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sync_out = s.second;
endmodule

// ### hdl/hwm_limit_cmp.sv
// Window comparison of one reading against its high and low limits
`timescale 1ns/1ps
module hwm_limit_cmp (
   input  wire logic [7:0] value,
   input  wire logic [7:0] high_limit,
   input  wire logic [7:0] low_limit,
   input  wire logic       is_signed,
   output logic            out_of_range
);
   always_comb begin
      if (is_signed) begin
         out_of_range = ($signed(value) > $signed(high_limit)) || ($signed(value) < $signed(low_limit));
      end else begin
         out_of_range = (value > high_limit) || (value < low_limit);
      end
   end
endmodule

// ### hdl/hwm_top.sv
// Hardware monitor control, status, voltage code, address latch and scan sequencer
//
// Behaviour
// - 12 V and own-supply out-of-limit set status2 bits
// - Remote diode short or open sets status2 bit6
// - Status2 read-only at 42h, resets to zero
// - Voltage code low shows four code pins
// - Code low bit7 turns shared pin into reset
// - Code high bit0 shows fifth pin when selected
// - Slave only; controller clocks and moves data
// - Slave address 010110 plus address pin level
// - Address pin latched once at power-up only
// - Every register one byte; temperatures two's complement
// - Power-up loads defaults, converter off, standby
// - Power-on clears limits; controller programs them first
// - Init bit soft-resets, keeps readings and limits, clears
// - Start bit runs roughly one-second scan loop
// - Fixed order remote, local, supply, 12, 5, 3.3, 2.5, core
// - Readings and flags readable any time
// - Clearing start halts loop, enters standby
// - Temperature results stored and compared against limits
// - Flag follows latest reading, refreshed every loop
// - Enabled reset pin pulses low on bit4 rise
// - Config bit5 selects fifth code input, default 12 V
`timescale 1ns/1ps
`include "hwm_regs.svh"
module hwm_top
   import hwm_pkg::*;
#(
   parameter int unsigned LOOP_CYCLES      = `HWM_LOOP_MS * `HWM_CLK_KHZ,
   parameter int unsigned RST_PULSE_CYCLES = `HWM_RST_PULSE_MS * `HWM_CLK_KHZ,
   // Identification bytes; values are arbitrary
   parameter hwm_byte_t   ID_MAKER         = 8'h5A,
   parameter hwm_byte_t   ID_STEP          = 8'h01
) (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       scl_pin,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   input  wire logic       address_select_pin,
   output logic            reset_pin_out,
   output logic            reset_pin_oe_n,
   input  wire logic [3:0] voltage_code_pins_low,
   input  wire logic       voltage_code_pin_high,
   output logic            conv_enable,
   output logic            conv_req,
   output logic [2:0]      conv_chan,
   input  wire logic       conv_done,
   input  wire logic [7:0] conv_data,
   input  wire logic       diode_fault
);
   localparam int CNT_W = $clog2(LOOP_CYCLES + 1);
   localparam int PW    = $clog2(RST_PULSE_CYCLES + 1);

   typedef struct packed {
      hwm_smb_st_t          smb;
      logic [3:0]           bitcnt;
      hwm_byte_t            shreg;
      logic [1:0]           byte_idx;
      logic                 rd;
      logic                 ack_seen;
      hwm_byte_t            ptr;
      logic                 sda_oe_n;
      logic                 sda_out;
      logic                 scl_q;
      logic                 sda_q;
      hwm_byte_t            cfg;
      hwm_byte_t            status1;
      hwm_byte_t            status2;
      logic                 rst_en;
      logic                 addr_lsb;
      logic                 addr_done;
      logic [1:0]           addr_dly;
      logic [7:0][7:0]      readings;
      logic [15:0][7:0]     limits;
      hwm_mon_st_t          mon;
      logic [2:0]           step;
      logic [CNT_W-1:0]     loop_cnt;
      logic                 conv_req;
      logic [2:0]           conv_chan;
      logic                 conv_enable;
      logic [PW-1:0]        pulse_cnt;
      logic                 pin_oe_n;
      logic                 pin_out;
   } hwm_state_t;

   hwm_state_t s;
   hwm_state_t next_s;

   logic [7:0] pins_sync;
   logic       scl_s;
   logic       sda_s;
   logic       addr_s;
   logic [3:0] vcode_s;
   logic       vcode4_s;
   hwm_byte_t  rd_val;
   logic       out_of_range;

   hwm_sync #(
      .WIDTH (8)
   ) u_sync (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .async_in ({voltage_code_pin_high, voltage_code_pins_low, address_select_pin, sda_in, scl_pin}),
      .sync_out (pins_sync)
   );

   assign scl_s    = pins_sync[0];
   assign sda_s    = pins_sync[1];
   assign addr_s   = pins_sync[2];
   assign vcode_s  = pins_sync[6:3];
   assign vcode4_s = pins_sync[7];

   // Scan order: remote, local, supply, 12 V, 5 V, 3.3 V, 2.5 V, core
   function automatic logic [2:0] seq_chan(input logic [2:0] step);
      logic [2:0] ch;
      ch = 3'h0;
      unique case (step)
         3'h0: ch = 3'h6;
         3'h1: ch = 3'h7;
         3'h2: ch = 3'h5;
         3'h3: ch = 3'h4;
         3'h4: ch = 3'h3;
         3'h5: ch = 3'h2;
         3'h6: ch = 3'h0;
         3'h7: ch = 3'h1;
      endcase
      return ch;
   endfunction

   function automatic hwm_byte_t reg_read(input hwm_state_t st, input logic [3:0] vc, input logic vc4);
      hwm_byte_t v;
      hwm_byte_t off;
      v   = 8'h00;
      off = 8'h00;
      if (st.ptr >= `HWM_CMD_READING_BASE && st.ptr <= `HWM_CMD_READING_LAST) begin
         off = st.ptr - `HWM_CMD_READING_BASE;
         v   = st.readings[off[2:0]];
      end else if (st.ptr >= `HWM_CMD_LIMIT_BASE && st.ptr <= `HWM_CMD_LIMIT_LAST) begin
         off = st.ptr - `HWM_CMD_LIMIT_BASE;
         v   = st.limits[off[3:0]];
      end else begin
         unique case (st.ptr)
            `HWM_CMD_CONFIG:     v = st.cfg;
            `HWM_CMD_STATUS1:    v = st.status1;
            `HWM_CMD_STATUS2:    v = st.status2 & `HWM_ST2_DEFINED;
            `HWM_CMD_VCODE_LOW:  v = {st.rst_en, 3'h0, vc};
            `HWM_CMD_VCODE_HIGH: v = `HWM_VCH_FIXED | {7'h00, vc4 & st.cfg[`HWM_CFG_SHARED_SEL]};
            `HWM_CMD_ID_MAKER:   v = ID_MAKER;
            `HWM_CMD_ID_STEP:    v = ID_STEP;
            default:             v = 8'h00;
         endcase
      end
      return v;
   endfunction

   assign rd_val = reg_read(s, vcode_s, vcode4_s);

   hwm_limit_cmp u_cmp (
      .value        (conv_data),
      .high_limit   (s.limits[{s.conv_chan, 1'b0}]),
      .low_limit    (s.limits[{s.conv_chan, 1'b1}]),
      .is_signed    (s.conv_chan[2] & s.conv_chan[1]),
      .out_of_range (out_of_range)
   );

   always_comb begin
      logic       scl_rise;
      logic       scl_fall;
      logic       start_cond;
      logic       stop_cond;
      logic       wr_en;
      hwm_byte_t  wr_data;
      hwm_byte_t  off;
      logic       do_init;
      logic       issue;

      next_s     = s;
      scl_rise   = scl_s & ~s.scl_q;
      scl_fall   = ~scl_s & s.scl_q;
      start_cond = scl_s & s.scl_q & s.sda_q & ~sda_s;
      stop_cond  = scl_s & s.scl_q & ~s.sda_q & sda_s;
      wr_en      = 1'b0;
      wr_data    = s.shreg;
      off        = 8'h00;
      do_init    = 1'b0;
      issue      = 1'b0;

      next_s.scl_q    = scl_s;
      next_s.sda_q    = sda_s;
      next_s.conv_req = 1'b0;
      next_s.sda_out  = 1'b0;
      next_s.pin_out  = 1'b0;

      // Address pin caught once after power-on release, never on soft init
      if (!s.addr_done) begin
         next_s.addr_dly = s.addr_dly + 2'h1;
         if (s.addr_dly == `HWM_ADDR_LATCH_DLY) begin
            next_s.addr_lsb  = addr_s;
            next_s.addr_done = 1'b1;
         end
      end

      // Slave side of the serial link; the controller owns the clock
      if (start_cond) begin
         next_s.smb      = SMB_RX;
         next_s.bitcnt   = 4'h0;
         next_s.byte_idx = 2'h0;
         next_s.sda_oe_n = 1'b1;
      end else if (stop_cond) begin
         next_s.smb      = SMB_IDLE;
         next_s.sda_oe_n = 1'b1;
      end else begin
         unique case (s.smb)
            SMB_IDLE: begin
            end
            SMB_RX: begin
               if (scl_rise && s.bitcnt < 4'h8) begin
                  next_s.shreg  = {s.shreg[6:0], sda_s};
                  next_s.bitcnt = s.bitcnt + 4'h1;
               end else if (scl_fall && s.bitcnt == 4'h8) begin
                  next_s.smb      = SMB_ACK;
                  next_s.sda_oe_n = 1'b0;
                  if (s.byte_idx != 2'h2) begin
                     next_s.byte_idx = s.byte_idx + 2'h1;
                  end
                  unique case (s.byte_idx)
                     2'h0: begin
                        // Address must match or the byte is ignored until the next start
                        if (s.shreg[7:1] == {`HWM_SLAVE_ADDR_HI, s.addr_lsb}) begin
                           next_s.rd = s.shreg[0];
                        end else begin
                           next_s.smb      = SMB_IDLE;
                           next_s.sda_oe_n = 1'b1;
                        end
                     end
                     2'h1: next_s.ptr = s.shreg;
                     default: wr_en = 1'b1;
                  endcase
               end
            end
            SMB_ACK: begin
               if (scl_fall) begin
                  if (s.rd) begin
                     next_s.smb      = SMB_TX;
                     next_s.shreg    = rd_val;
                     next_s.sda_oe_n = rd_val[7];
                     next_s.bitcnt   = 4'h1;
                  end else begin
                     next_s.smb      = SMB_RX;
                     next_s.sda_oe_n = 1'b1;
                     next_s.bitcnt   = 4'h0;
                  end
               end
            end
            SMB_TX: begin
               if (scl_fall) begin
                  if (s.bitcnt == 4'h8) begin
                     next_s.smb      = SMB_TXACK;
                     next_s.sda_oe_n = 1'b1;
                  end else begin
                     next_s.shreg    = {s.shreg[6:0], 1'b0};
                     next_s.sda_oe_n = s.shreg[6];
                     next_s.bitcnt   = s.bitcnt + 4'h1;
                  end
               end
            end
            SMB_TXACK: begin
               if (scl_rise) begin
                  next_s.ack_seen = ~sda_s;
               end else if (scl_fall) begin
                  // Master ack repeats the same register; no auto-increment
                  if (s.ack_seen) begin
                     next_s.smb      = SMB_TX;
                     next_s.shreg    = rd_val;
                     next_s.sda_oe_n = rd_val[7];
                     next_s.bitcnt   = 4'h1;
                  end else begin
                     next_s.smb = SMB_IDLE;
                  end
               end
            end
            default: begin
               next_s.smb      = SMB_IDLE;
               next_s.sda_oe_n = 1'b1;
            end
         endcase
      end

      // Register writes; writes to read-only commands are dropped
      if (wr_en) begin
         if (s.ptr >= `HWM_CMD_LIMIT_BASE && s.ptr <= `HWM_CMD_LIMIT_LAST) begin
            off = s.ptr - `HWM_CMD_LIMIT_BASE;
            next_s.limits[off[3:0]] = wr_data;
         end else if (s.ptr == `HWM_CMD_CONFIG) begin
            next_s.cfg = (wr_data & `HWM_CFG_WRITE_MASK) | `HWM_CFG_RESET;
            if (wr_data[`HWM_CFG_RST_PULSE] && !s.cfg[`HWM_CFG_RST_PULSE] && s.rst_en) begin
               next_s.pulse_cnt = PW'(RST_PULSE_CYCLES);
               next_s.pin_oe_n  = 1'b0;
            end
            do_init = wr_data[`HWM_CFG_INIT];
         end else if (s.ptr == `HWM_CMD_VCODE_LOW) begin
            next_s.rst_en = wr_data[`HWM_VCL_RST_EN];
         end
      end

      // Reset pin pulse, held for the full count unless a soft init releases it
      if (s.pulse_cnt > PW'(1)) begin
         next_s.pulse_cnt = s.pulse_cnt - PW'(1);
      end else if (s.pulse_cnt == PW'(1)) begin
         next_s.pulse_cnt = '0;
         next_s.pin_oe_n  = 1'b1;
      end

      // Soft init: config, status and reset enable back to defaults; readings and limits kept
      if (do_init) begin
         next_s.cfg         = `HWM_CFG_RESET;
         next_s.status1     = 8'h00;
         next_s.status2     = 8'h00;
         next_s.rst_en      = 1'b0;
         next_s.pulse_cnt   = '0;
         next_s.pin_oe_n    = 1'b1;
      end

      // Scan sequencer
      unique case (s.mon)
         MON_STANDBY: begin
            if (next_s.cfg[`HWM_CFG_START]) begin
               next_s.step     = 3'h0;
               next_s.loop_cnt = '0;
               issue           = 1'b1;
            end
         end
         MON_CONV: begin
            if (s.loop_cnt < CNT_W'(LOOP_CYCLES - 1)) begin
               next_s.loop_cnt = s.loop_cnt + CNT_W'(1);
            end
            if (conv_done) begin
               // Flag update lands after init clear so a finishing result is never lost
               next_s.readings[s.conv_chan] = conv_data;
               unique case (s.conv_chan)
                  3'h0, 3'h1, 3'h2, 3'h3: next_s.status1[s.conv_chan] = out_of_range;
                  3'h4: next_s.status2[`HWM_ST2_12V] = out_of_range;
                  3'h5: next_s.status2[`HWM_ST2_VDD] = out_of_range;
                  3'h6: begin
                     next_s.status1[5]                = out_of_range;
                     next_s.status2[`HWM_ST2_DIODE]   = diode_fault;
                  end
                  3'h7: next_s.status1[4] = out_of_range;
               endcase
               if (s.step == 3'h7) begin
                  next_s.mon = MON_WAIT;
               end else begin
                  next_s.step = s.step + 3'h1;
                  issue       = 1'b1;
               end
            end
         end
         MON_WAIT: begin
            if (s.loop_cnt >= CNT_W'(LOOP_CYCLES - 1)) begin
               next_s.loop_cnt = '0;
               next_s.step     = 3'h0;
               issue           = 1'b1;
            end else begin
               next_s.loop_cnt = s.loop_cnt + CNT_W'(1);
            end
         end
         default: begin
            next_s.mon = MON_STANDBY;
         end
      endcase

      if (issue) begin
         next_s.mon         = MON_CONV;
         next_s.conv_enable = 1'b1;
         next_s.conv_req    = 1'b1;
         next_s.conv_chan   = seq_chan(next_s.step);
      end

      // Start cleared: abandon any conversion and power down
      if (!next_s.cfg[`HWM_CFG_START]) begin
         next_s.mon         = MON_STANDBY;
         next_s.conv_enable = 1'b0;
         next_s.conv_req    = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s             <= '0;
         s.smb         <= SMB_IDLE;
         s.mon         <= MON_STANDBY;
         s.sda_oe_n    <= 1'b1;
         s.scl_q       <= 1'b1;
         s.sda_q       <= 1'b1;
         s.cfg         <= `HWM_CFG_RESET;
         s.pin_oe_n    <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign sda_out        = s.sda_out;
   assign sda_oe_n       = s.sda_oe_n;
   assign reset_pin_out  = s.pin_out;
   assign reset_pin_oe_n = s.pin_oe_n;
   assign conv_enable    = s.conv_enable;
   assign conv_req       = s.conv_req;
   assign conv_chan      = s.conv_chan;
endmodule

// ### verif/hwm_chk.sv
// Concurrent checks on the monitor's serial, scan and reset-pin ports
`timescale 1ns/1ps
module hwm_chk #(
   parameter int unsigned RST_PULSE_CYCLES = 5000000
) (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       scl_pin,
   input  wire logic       sda_out,
   input  wire logic       sda_oe_n,
   input  wire logic       reset_pin_oe_n,
   input  wire logic       conv_enable,
   input  wire logic       conv_req,
   input  wire logic [2:0] conv_chan,
   input  wire logic       conv_done
);
   // Successor of each channel in the scan; channel 1 closes the loop
   localparam logic [2:0] NXT [8] = '{3'h1, 3'h0, 3'h0, 3'h2, 3'h3, 3'h4, 3'h7, 3'h5};
   logic [31:0] low_cnt;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   always_ff @(posedge ref_clk) begin
      if (!reset_n || reset_pin_oe_n) begin
         low_cnt <= 32'h0;
      end else begin
         low_cnt <= low_cnt + 32'h1;
      end
   end

   sequence s_first_req;
      conv_req && conv_chan == 3'h6;
   endsequence
   sequence s_next_req;
      conv_req && conv_chan == NXT[$past(conv_chan)];
   endsequence
   // A stop or init landing on a result may legally drop the follow-up
   sequence s_halted;
      !conv_enable;
   endsequence

   a_scan_first: assert property ($rose(conv_enable) |-> s_first_req)
      else $error("scan did not open with the remote channel");
   a_scan_order: assert property (conv_done && conv_enable && conv_chan != 3'h1 |=> s_halted or s_next_req)
      else $error("scan channel out of order");
   a_loop_wait: assert property (conv_done && conv_enable && conv_chan == 3'h1 |=> !conv_req)
      else $error("loop restarted without waiting");
   a_req_single: assert property (conv_req |=> !conv_req)
      else $error("conversion request longer than one cycle");
   a_req_enabled: assert property (conv_req |-> conv_enable)
      else $error("conversion requested in standby");
   a_chan_held: assert property (conv_enable && !conv_req |-> $stable(conv_chan))
      else $error("channel moved between requests");
   a_pulse_len: assert property ($rose(reset_pin_oe_n) |-> low_cnt == RST_PULSE_CYCLES)
      else $error("reset pulse length wrong");
   a_pulse_cap: assert property (!reset_pin_oe_n |-> low_cnt < RST_PULSE_CYCLES)
      else $error("reset pulse too long");
   a_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_pin)
      else $error("data line moved while serial clock high");
   a_sda_od: assert property (!sda_oe_n |-> !sda_out)
      else $error("data line driven high");
   a_wake_idle: assert property ($rose(reset_n) |-> !conv_enable && reset_pin_oe_n && sda_oe_n)
      else $error("device not idle after reset");
endmodule

bind hwm_top hwm_chk #(.RST_PULSE_CYCLES(RST_PULSE_CYCLES)) chk (
   .ref_clk(ref_clk), .reset_n(reset_n), .scl_pin(scl_pin), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
   .reset_pin_oe_n(reset_pin_oe_n), .conv_enable(conv_enable), .conv_req(conv_req),
   .conv_chan(conv_chan), .conv_done(conv_done)
);

// ### verif/hwm_smb_master.sv
// Serial bus controller model that clocks and moves every byte
`timescale 1ns/1ps
module hwm_smb_master (
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   logic [6:0] addr;

   initial begin
      scl = 1'h1;
      sda_low = 1'h0;
      addr = 7'h2D;
   end

   // Controller owns the clock; released data floats to the pull-up
   task automatic bit_io(input logic b, output logic s);
      sda_low = !b;
      #16 scl = 1'h1;
      #32 s = sda;
      scl = 1'h0;
      #16;
   endtask

   task automatic start();
      sda_low = 1'h0;
      #16 scl = 1'h1;
      #16 sda_low = 1'h1;
      #16 scl = 1'h0;
      #16;
   endtask

   task automatic stop();
      sda_low = 1'h1;
      #16 scl = 1'h1;
      #16 sda_low = 1'h0;
      #16;
   endtask

   task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(1'h1, a);
      ack = !a;
   endtask

   task automatic write_reg(input logic [7:0] cmd, input logic [7:0] data, output logic ok);
      logic [7:0] q;
      logic       a0;
      logic       a1;
      logic       a2;
      start();
      byte_io({addr, 1'h0}, q, a0);
      byte_io(cmd, q, a1);
      byte_io(data, q, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask

   // Read byte: final bit released, so the device sees a not-acknowledge
   task automatic read_reg(input logic [7:0] cmd, output logic [7:0] q);
      logic [7:0] d;
      logic       a;
      start();
      byte_io({addr, 1'h0}, d, a);
      byte_io(cmd, d, a);
      start();
      byte_io({addr, 1'h1}, d, a);
      byte_io(8'hFF, q, a);
      stop();
   endtask
endmodule

// ### verif/test_hw_monitor_status_and_sequencer.sv
// Self-checking bench for the hardware monitor top
`timescale 1ns/1ps
module test_hw_monitor_status_and_sequencer;
   import hwm_pkg::*;
   localparam int LOOP = 400;
   localparam int PULSE = 50;
   // Identification bytes; values are arbitrary
   localparam logic [7:0] ID_M = 8'hC3;
   localparam logic [7:0] ID_S = 8'h3C;
   typedef struct {logic [7:0] cmd; logic [7:0] exp;} hwm_row_t;
   logic       ref_clk;
   logic       reset_n;
   logic       scl_pin;
   logic       m_low;
   logic       sda_out;
   logic       sda_oe_n;
   logic       address_select_pin;
   logic       reset_pin_oe_n;
   logic       reset_pin_out;
   logic [3:0] voltage_code_pins_low;
   logic       voltage_code_pin_high;
   logic       conv_enable;
   logic       conv_req;
   logic [2:0] conv_chan;
   logic       conv_done = 1'h0;
   logic [7:0] conv_data = 8'h00;
   logic       diode_fault = 1'h0;
   logic       fault_v;
   logic       ok;
   logic [7:0] conv_val [8];
   logic [7:0] lims [6];
   logic [2:0] ord [8];
   logic [2:0] seen [$];
   hwm_row_t   rows [9];
   int         n;
   int         n_fail;
   int         tests_run;
   wire        sda_wire = !m_low && (sda_oe_n || sda_out);

   hwm_top #(.LOOP_CYCLES(LOOP), .RST_PULSE_CYCLES(PULSE), .ID_MAKER(ID_M), .ID_STEP(ID_S)) dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .scl_pin(scl_pin), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .address_select_pin(address_select_pin), .reset_pin_out(reset_pin_out),
      .reset_pin_oe_n(reset_pin_oe_n), .voltage_code_pins_low(voltage_code_pins_low),
      .voltage_code_pin_high(voltage_code_pin_high), .conv_enable(conv_enable), .conv_req(conv_req),
      .conv_chan(conv_chan), .conv_done(conv_done), .conv_data(conv_data), .diode_fault(diode_fault));
   hwm_smb_master mst (.scl(scl_pin), .sda_low(m_low), .sda(sda_wire));

   initial begin
      ref_clk = 1'h0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Converter answers one cycle after each request
   always @(posedge ref_clk) begin
      conv_done <= 1'h0;
      if (conv_req) begin
         seen.push_back(conv_chan);
         conv_done <= 1'h1;
         conv_data <= conv_val[conv_chan];
         diode_fault <= fault_v;
      end
   end

   task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rd(input logic [7:0] cmd, input logic [7:0] exp, input string what);
      logic [7:0] v;
      mst.read_reg(cmd, v);
      check(what, v, exp);
   endtask

   task automatic step(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      #300000;
      n_fail++;
      close_out();
   end

   initial begin
      reset_n = 1'h0;
      address_select_pin = 1'h1;
      voltage_code_pins_low = 4'hA;
      voltage_code_pin_high = 1'h1;
      fault_v = 1'h1;
      n_fail = 0;
      tests_run = 0;
      conv_val = '{8'h80, 8'h80, 8'h80, 8'h80, 8'hD0, 8'hC0, 8'hFC, 8'h19};
      lims = '{8'hC8, 8'hB4, 8'hC8, 8'hB4, 8'h50, 8'hF0};
      ord = '{3'h6, 3'h7, 3'h5, 3'h4, 3'h3, 3'h2, 3'h0, 3'h1};
      rows = '{'{8'h42, 8'h00}, '{8'h40, 8'h08}, '{8'h47, 8'h0A},
               '{8'h49, 8'h80}, '{8'h33, 8'h00}, '{8'h37, 8'h00},
               '{8'h3E, ID_M}, '{8'h3F, ID_S}, '{8'h50, 8'h00}};
      step(3);
      reset_n = 1'h1;
      step(12);
      // Address pin moves after the latch window and must not matter
      address_select_pin = 1'h0;
      foreach (rows[i]) rd(rows[i].cmd, rows[i].exp, "reset value");
      mst.addr = 7'h2C;
      mst.write_reg(8'h40, 8'h01, ok);
      check("foreign address ack", {7'h00, ok}, 8'h00);
      mst.addr = 7'h2D;
      mst.write_reg(8'h40, 8'h20, ok);
      check("own address ack", {7'h00, ok}, 8'h01);
      rd(8'h49, 8'h81, "code high");
      voltage_code_pins_low = 4'h5;
      step(4);
      rd(8'h47, 8'h05, "code low");
      for (int i = 0; i < 6; i++) mst.write_reg(8'h33 + 8'(i), lims[i], ok);
      mst.write_reg(8'h40, 8'h21, ok);
      step(20);
      foreach (ord[i]) check("scan order", {5'h00, seen[i]}, {5'h00, ord[i]});
      rd(8'h42, 8'h41, "status two");
      rd(8'h41, 8'h1F, "status one signed remote");
      rd(8'h24, 8'hD0, "12 V reading");
      rd(8'h26, 8'hFC, "remote reading");
      conv_val[4] = 8'hC0;
      conv_val[5] = 8'hFF;
      fault_v = 1'h0;
      step(LOOP + 20);
      rd(8'h42, 8'h02, "status two refresh");
      mst.write_reg(8'h40, 8'h20, ok);
      n = seen.size();
      step(LOOP + 20);
      check("standby enable", {7'h00, conv_enable}, 8'h00);
      check("standby scans", 8'(seen.size() - n), 8'h00);
      mst.write_reg(8'h40, 8'h80, ok);
      rd(8'h40, 8'h08, "config after init");
      rd(8'h42, 8'h00, "status after init");
      rd(8'h33, 8'hC8, "limit after init");
      rd(8'h24, 8'hC0, "reading after init");
      mst.write_reg(8'h47, 8'h80, ok);
      rd(8'h47, 8'h85, "reset enable");
      mst.write_reg(8'h40, 8'h10, ok);
      check("reset pin low", {6'h00, reset_pin_oe_n, reset_pin_out}, 8'h00);
      step(PULSE);
      check("reset pin free", {6'h00, reset_pin_oe_n, reset_pin_out}, 8'h02);
      // Second power-on with the address pin now low moves the device to the other address
      reset_n = 1'h0;
      step(3);
      reset_n = 1'h1;
      check("wake reset pin", {6'h00, reset_pin_oe_n, reset_pin_out}, 8'h02);
      step(12);
      mst.addr = 7'h2C;
      rd(8'h47, 8'h05, "code low after power-on");
      close_out();
   end
endmodule
